// ### dv/stack_memory.sv
// Behavioural byte-wide main memory holding the stack area
`timescale 1ns/1ns
`default_nettype none
module stack_memory (
   // Clock and wait-state setting
   input  wire logic        clock,
   input  wire logic [3:0]  waitCycles,
   // Access port
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic        memByte,
   input  wire logic [15:0] memAddr,
   input  wire logic [15:0] memWdata,
   output logic [15:0]      memRdata,
   output logic             memAck
);
   logic [7:0]  bytes [0:65535];
   logic [3:0]  waitCnt = 4'h0;
   logic [15:0] word;
   // Ack only after the requested wait states, so slow memory is exercised too
   assign memAck = memReq && (waitCnt == waitCycles);
   // Byte reads show the byte on both lanes
   assign word = memByte ? {2{bytes[memAddr]}} : {bytes[memAddr | 16'h0001], bytes[memAddr]};
   // Read data is not valid outside an ack, so the bus shows the inverse then
   assign memRdata = memAck ? word : ~word;
   // Wait counter and little-endian stores
   always @(posedge clock) begin
      waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
      if (memAck && memWrite) begin
         bytes[memAddr] <= memWdata[7:0];
         if (!memByte) bytes[memAddr | 16'h0001] <= memWdata[15:8];
      end
   end
endmodule : stack_memory
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the stack linkage unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import stack_link_pkg::*;
   logic        clock = 1'b0, nrst = 1'b0, cmdValid = 1'b0, cmdByte = 1'b0, regWrite = 1'b0;
   stackOp_t    cmdOp = OP_PUSH;
   logic [2:0]  cmdReg = 3'h0, regWrIdx = 3'h0;
   logic [15:0] cmdData = 16'h0000, cmdPsw = 16'h0000, regWrData = 16'h0000;
   logic        cmdReady, cmdDone, memReq, memWrite, memByte, memAck;
   logic [15:0] resultData, stackPtr, progCount, memAddr, memWdata, memRdata;
   logic [3:0]  waitCycles = 4'h0;
   int          fails = 0, checks = 0, cycles = 0;

   always #10 clock = ~clock;

   stack_linkage_unit DUT (.clock(clock), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdOp(cmdOp), .cmdReg(cmdReg), .cmdByte(cmdByte), .cmdData(cmdData), .cmdPsw(cmdPsw),
      .cmdDone(cmdDone), .resultData(resultData), .regWrite(regWrite), .regWrIdx(regWrIdx),
      .regWrData(regWrData), .stackPtr(stackPtr), .progCount(progCount), .memReq(memReq),
      .memWrite(memWrite), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck));
   stack_memory ram (.clock(clock), .waitCycles(waitCycles), .memReq(memReq), .memWrite(memWrite),
      .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [15:0] rdw(input logic [15:0] a);
      return {ram.bytes[a + 16'h0001], ram.bytes[a]};
   endfunction : rdw
   // Direct register load, held for exactly one taking edge
   task automatic regw(input logic [2:0] idx, input logic [15:0] val);
      @(posedge clock);
      regWrite <= 1'b1;
      regWrIdx <= idx;
      regWrData <= val;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : regw
   // One command; only issued from idle, so it is taken at the next edge
   task automatic cmd(input stackOp_t op, input logic [2:0] r, input logic b, input logic [15:0] d, p);
      int n;
      @(posedge clock);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdReg <= r;
      cmdByte <= b;
      cmdData <= d;
      cmdPsw <= p;
      @(posedge clock);
      cmdValid <= 1'b0;
      // Busy from the taking edge, so a second command would be refused here
      @(negedge clock);
      chk({15'h0000, cmdReady}, 16'h0000);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (cmdDone !== 1'b1 && n < 40);
      chk({15'h0000, cmdDone}, 16'h0001);
      chk({15'h0000, cmdReady}, 16'h0001);
   endtask : cmd
   task automatic t_word();
      cmd(OP_PUSH, 3'h6, 1'b0, 16'hA5A5, 16'h0000);
      cmd(OP_PUSH, 3'h6, 1'b0, 16'h5A5A, 16'h0000);
      chk(stackPtr, 16'h0FFC);
      chk(rdw(16'h0FFC), 16'h5A5A);
      chk(rdw(16'h0FFE), 16'hA5A5);
      cmd(OP_POP, 3'h6, 1'b0, 16'h0000, 16'h0000);
      chk(resultData, 16'h5A5A);
      chk(stackPtr, 16'h0FFE);
      cmd(OP_POP, 3'h6, 1'b0, 16'h0000, 16'h0000);
      chk(resultData, 16'hA5A5);
   endtask : t_word
   // Byte stack in another register steps by one; the hardware stack still steps by two
   task automatic t_byte();
      regw(3'h3, 16'h2001);
      cmd(OP_PUSH, 3'h3, 1'b1, 16'h00C3, 16'h0000);
      cmd(OP_PUSH, 3'h3, 1'b1, 16'h003C, 16'h0000);
      chk({8'h00, ram.bytes[16'h2000]}, 16'h00C3);
      chk({8'h00, ram.bytes[16'h1FFF]}, 16'h003C);
      cmd(OP_POP, 3'h3, 1'b1, 16'h0000, 16'h0000);
      chk(resultData, 16'h003C);
      cmd(OP_POP, 3'h3, 1'b1, 16'h0000, 16'h0000);
      chk(resultData, 16'h00C3);
      cmd(OP_PUSH, 3'h6, 1'b1, 16'h0077, 16'h0000);
      chk(stackPtr, 16'h0FFE);
      chk(rdw(16'h0FFE), 16'hA577);
      cmd(OP_POP, 3'h6, 1'b1, 16'h0000, 16'h0000);
      chk(resultData, 16'h0077);
      chk(stackPtr, 16'h1000);
   endtask : t_byte
   task automatic t_call();
      regw(3'h5, 16'h1234);
      regw(3'h7, 16'h0100);
      cmd(OP_CALL, 3'h5, 1'b0, 16'h0400, 16'h0000);
      chk(rdw(16'h0FFE), 16'h1234);
      chk(stackPtr, 16'h0FFE);
      chk(progCount, 16'h0400);
      cmd(OP_RETURN, 3'h5, 1'b0, 16'h0000, 16'h0000);
      chk(progCount, 16'h0100);
      chk(stackPtr, 16'h1000);
      cmd(OP_CALL, 3'h5, 1'b0, 16'h0600, 16'h0000);
      chk(rdw(16'h0FFE), 16'h1234);
      cmd(OP_RETURN, 3'h5, 1'b0, 16'h0000, 16'h0000);
      cmd(OP_CALL, 3'h7, 1'b0, 16'h0500, 16'h0000);
      chk(rdw(16'h0FFE), 16'h0100);
      chk(progCount, 16'h0500);
      cmd(OP_RETURN, 3'h7, 1'b0, 16'h0000, 16'h0000);
      chk(progCount, 16'h0100);
   endtask : t_call
   // Trap against slow memory, naming another register that must be ignored
   task automatic t_trap();
      waitCycles <= 4'h3;
      cmd(OP_TRAP, 3'h3, 1'b0, 16'h0200, 16'h00E4);
      waitCycles <= 4'h0;
      chk(rdw(16'h0FFE), 16'h00E4);
      chk(rdw(16'h0FFC), 16'h0100);
      chk(stackPtr, 16'h0FFC);
      chk(progCount, 16'h0200);
   endtask : t_trap
   task automatic t_fifty();
      for (int i = 0; i < 50; i++) cmd(OP_PUSH, 3'h6, 1'b0, 16'(i), 16'h0000);
      chk(stackPtr, 16'h0F98);
      chk(rdw(16'h0F98), 16'h0031);
   endtask : t_fifty
   task automatic end_of_test();
      $display("Compares %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   // A hang is cut short well beyond the few hundred cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      @(negedge clock);
      chk(stackPtr, STACK_RESET);
      t_word();
      t_byte();
      t_call();
      t_trap();
      t_fifty();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire

// ### hdl/stack_link_pkg.sv
// Package of constants and types for the stack linkage unit
// What this block does
// R1: Push uses autodecrement, word or byte
// R2: Pop uses autoincrement, word or byte
// R3: Pointer holds last occupied stack location
// R4: Call pushes link register, loads return, jumps
// R5: Program counter as link pushes return address
// R6: Return restores link and resumes there
// R7: Trap pushes program counter and status word
// R8: Linkage always uses hardware stack register
// R9: Word items take two byte addresses
// R10: Hardware stack register steps whole words only
// R11: Decrement before access, increment after access
package stack_link_pkg;
   localparam int WORD_W = 16;
   localparam int REG_N = 8;
   localparam logic [2:0] HW_STACK_IDX = 3'h6;
   localparam logic [2:0] PC_IDX = 3'h7;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] STACK_RESET = 16'h1000;

   // Operation codes accepted on the command port
   typedef enum logic [2:0] {
      OP_PUSH = 3'h0,
      OP_POP = 3'h1,
      OP_CALL = 3'h2,
      OP_RETURN = 3'h3,
      OP_TRAP = 3'h4
   } stackOp_t;

   // One-hot sequencer states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_PUSH_WR = 7'h02,
      ST_POP_RD = 7'h04,
      ST_CALL_WR = 7'h08,
      ST_RET_RD = 7'h10,
      ST_TRAP_PSW = 7'h20,
      ST_TRAP_PC = 7'h40
   } seqState_t;
endpackage : stack_link_pkg

// ### hdl/stack_linkage_unit.sv
// Stack linkage sequencer with register file and memory port
`timescale 1ns/1ns
`default_nettype none
module stack_linkage_unit (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          nrst,
   // Command port
   input  wire logic                          cmdValid,
   output logic                               cmdReady,
   input  wire stack_link_pkg::stackOp_t      cmdOp,
   input  wire logic [2:0]                    cmdReg,
   input  wire logic                          cmdByte,
   input  wire logic [15:0]                   cmdData,
   input  wire logic [15:0]                   cmdPsw,
   output logic                               cmdDone,
   output logic [15:0]                        resultData,
   // Register file write port
   input  wire logic                          regWrite,
   input  wire logic [2:0]                    regWrIdx,
   input  wire logic [15:0]                   regWrData,
   // Register visibility
   output logic [15:0]                        stackPtr,
   output logic [15:0]                        progCount,
   // Memory port
   output logic                               memReq,
   output logic                               memWrite,
   output logic                               memByte,
   output logic [15:0]                        memAddr,
   output logic [15:0]                        memWdata,
   input  wire logic [15:0]                   memRdata,
   input  wire logic                          memAck
);
   import stack_link_pkg::*;

   seqState_t   state_reg, state_next;
   logic [15:0] regs_reg [REG_N];
   logic [2:0]  opReg_reg;
   logic        opByte_reg;
   logic [15:0] opData_reg;
   logic [15:0] opPsw_reg;
   logic [15:0] resultData_reg;
   logic        done_reg;
   logic [15:0] ptrCur, ptrDown, ptrUp;
   logic [2:0]  ptrIdx;

   // Linkage uses the hardware stack register; push and pop name their own pointer
   assign ptrIdx = (state_reg == ST_PUSH_WR || state_reg == ST_POP_RD) ? opReg_reg : HW_STACK_IDX; // R8
   assign ptrCur = regs_reg[ptrIdx];

   stack_step stepper (
      .pointer     (ptrCur),
      .regIdx      (ptrIdx),
      .byteOp      (opByte_reg && (state_reg == ST_PUSH_WR || state_reg == ST_POP_RD)),
      .decremented (ptrDown),
      .incremented (ptrUp)
   );

   assign cmdReady = (state_reg == ST_IDLE);
   assign cmdDone = done_reg;
   assign resultData = resultData_reg;
   assign stackPtr = regs_reg[HW_STACK_IDX];
   assign progCount = regs_reg[PC_IDX];

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmdValid) begin
               case (cmdOp)
                  OP_PUSH: state_next = ST_PUSH_WR;
                  OP_POP: state_next = ST_POP_RD;
                  OP_CALL: state_next = ST_CALL_WR;
                  OP_RETURN: state_next = ST_RET_RD;
                  OP_TRAP: state_next = ST_TRAP_PSW;
                  default: state_next = ST_IDLE;
               endcase
            end
         end
         ST_PUSH_WR, ST_POP_RD, ST_CALL_WR, ST_RET_RD, ST_TRAP_PC: begin
            if (memAck) state_next = ST_IDLE;
         end
         ST_TRAP_PSW: begin
            if (memAck) state_next = ST_TRAP_PC; // R7
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) state_reg <= ST_IDLE;
      else state_reg <= state_next;
   end

   // Command capture
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         opReg_reg <= 3'h0;
         opByte_reg <= 1'b0;
         opData_reg <= 16'h0000;
         opPsw_reg <= 16'h0000;
      end else if (state_reg == ST_IDLE && cmdValid) begin
         opReg_reg <= cmdReg;
         opByte_reg <= cmdByte;
         opData_reg <= cmdData;
         opPsw_reg <= cmdPsw;
      end
   end

   // Memory port: pointer stepped down before a write, old value used for reads
   always_comb begin
      memReq = 1'b0;
      memWrite = 1'b0;
      memByte = 1'b0;
      memAddr = ptrCur;
      memWdata = 16'h0000;
      case (state_reg)
         ST_PUSH_WR: begin
            memReq = 1'b1;
            memWrite = 1'b1;
            memByte = opByte_reg;
            memAddr = ptrDown; // R1 R11
            memWdata = opData_reg;
         end
         ST_POP_RD: begin
            memReq = 1'b1;
            memByte = opByte_reg;
            memAddr = ptrCur; // R2 R3
         end
         ST_CALL_WR: begin
            memReq = 1'b1;
            memWrite = 1'b1;
            memAddr = ptrDown; // R4 R5
            memWdata = regs_reg[opReg_reg]; // R4 R5
         end
         ST_RET_RD: begin
            memReq = 1'b1;
            memAddr = ptrCur; // R6
         end
         ST_TRAP_PSW: begin
            memReq = 1'b1;
            memWrite = 1'b1;
            memAddr = ptrDown;
            memWdata = opPsw_reg; // R7
         end
         ST_TRAP_PC: begin
            memReq = 1'b1;
            memWrite = 1'b1;
            memAddr = ptrDown;
            memWdata = regs_reg[PC_IDX]; // R7
         end
         default: memReq = 1'b0;
      endcase
   end

   // Register file updates; a command completes on the last memory acknowledge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < REG_N; i++) regs_reg[i] <= REG_RESET;
         regs_reg[HW_STACK_IDX] <= STACK_RESET;
      end else if (memAck && memReq) begin
         case (state_reg)
            ST_PUSH_WR, ST_TRAP_PSW: regs_reg[ptrIdx] <= ptrDown; // R3
            ST_POP_RD: regs_reg[ptrIdx] <= ptrUp; // R2 R11
            ST_CALL_WR: begin
               regs_reg[HW_STACK_IDX] <= ptrDown; // R4
               if (opReg_reg != PC_IDX) regs_reg[opReg_reg] <= regs_reg[PC_IDX]; // R4
               regs_reg[PC_IDX] <= opData_reg; // R4 R5
            end
            ST_RET_RD: begin
               regs_reg[HW_STACK_IDX] <= ptrUp;
               regs_reg[PC_IDX] <= regs_reg[opReg_reg]; // R6
               if (opReg_reg != PC_IDX) regs_reg[opReg_reg] <= memRdata; // R6
               else regs_reg[PC_IDX] <= memRdata; // R6
            end
            // One item for the last trap write, so pointer step and vector load both happen
            ST_TRAP_PC: begin
               regs_reg[HW_STACK_IDX] <= ptrDown; // R3 R8
               regs_reg[PC_IDX] <= opData_reg; // R7
            end
            default: regs_reg[PC_IDX] <= regs_reg[PC_IDX];
         endcase
      end else if (regWrite && state_reg == ST_IDLE) begin
         regs_reg[regWrIdx] <= regWrData;
      end
   end

   // Completion pulse and popped data
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         done_reg <= 1'b0;
         resultData_reg <= 16'h0000;
      end else begin
         done_reg <= memAck && memReq && state_reg != ST_TRAP_PSW;
         if (memAck && state_reg == ST_POP_RD)
            resultData_reg <= opByte_reg ? {8'h00, memRdata[7:0]} : memRdata;
      end
   end

   sequence pushStart;
      state_reg == ST_PUSH_WR && memAck;
   endsequence

   // Trap linkage is two writes: status word first, then the interrupted counter
   sequence trapPswDone;
      state_reg == ST_TRAP_PSW && memAck;
   endsequence

   sequence trapPcDone;
      state_reg == ST_TRAP_PC && memAck;
   endsequence

   AST_PUSH_STEP: assert property (@(posedge clock) disable iff (!nrst) // R1
      pushStart |=> regs_reg[opReg_reg] == $past(ptrDown)) else $error("Push pointer wrong");
   AST_POP_ADDR: assert property (@(posedge clock) disable iff (!nrst) // R2
      state_reg == ST_POP_RD |-> memAddr == regs_reg[opReg_reg]) else $error("Pop address wrong");
   AST_HW_WORD: assert property (@(posedge clock) disable iff (!nrst) // R10
      $changed(regs_reg[HW_STACK_IDX]) && !$past(regWrite)
      |-> regs_reg[HW_STACK_IDX][0] == $past(regs_reg[HW_STACK_IDX][0]))
      else $error("Hardware stack stepped by byte");
   AST_CALL_JUMP: assert property (@(posedge clock) disable iff (!nrst) // R4
      state_reg == ST_CALL_WR && memAck |=> progCount == $past(opData_reg)) else $error("Call did not jump");
   AST_CALL_SP: assert property (@(posedge clock) disable iff (!nrst) // R8
      state_reg == ST_CALL_WR |-> memAddr == stackPtr - WORD_STEP) else $error("Call push address wrong");
   AST_RET_POP: assert property (@(posedge clock) disable iff (!nrst) // R6
      state_reg == ST_RET_RD && memAck |=> stackPtr == $past(stackPtr) + WORD_STEP) else $error("Return pop wrong");
   AST_TRAP_SEQ: assert property (@(posedge clock) disable iff (!nrst) // R7
      trapPswDone |=> state_reg == ST_TRAP_PC) else $error("Trap sequence broken");
   // Handler entry must see the vector loaded and the pointer on the last trap word
   AST_TRAP_ENTRY: assert property (@(posedge clock) disable iff (!nrst) // R7
      trapPcDone |=> progCount == $past(opData_reg) && stackPtr == $past(ptrDown))
      else $error("Trap entry wrong");
   AST_PUSH_WORD: assert property (@(posedge clock) disable iff (!nrst) // R9
      state_reg == ST_PUSH_WR && !opByte_reg |-> memAddr == regs_reg[opReg_reg] - WORD_STEP)
      else $error("Word step wrong");
endmodule : stack_linkage_unit
`default_nettype wire

// ### hdl/stack_step.sv
// Pointer step arithmetic for autoincrement and autodecrement
`timescale 1ns/1ns
`default_nettype none
module stack_step (
   // Operand
   input  wire logic [15:0] pointer,
   input  wire logic [2:0]  regIdx,
   input  wire logic        byteOp,
   // Results
   output logic [15:0]      decremented,
   output logic [15:0]      incremented
);
   import stack_link_pkg::*;
   logic [15:0] step;

   // Hardware stack register keeps word alignment even on byte moves
   always_comb begin
      step = (byteOp && regIdx != HW_STACK_IDX) ? BYTE_STEP : WORD_STEP; // R10 R9
      decremented = pointer - step; // R11
      incremented = pointer + step; // R11
   end
endmodule : stack_step
`default_nettype wire
